// file: logic/hcsr_regs.sv
// hypervisor configuration, system control, syndrome and table base bank
// assumes an apb master on clk_sys_in and core status inputs on the same clock
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Contract
// RQ1: configuration register resets to 0x00000002
// RQ2: trap bit plus nonsecure routes level1 exceptions upward
// RQ3: trap forces level1 mmu enable to zero
// RQ4: trap forces fiq irq abort routing on
// RQ5: trap disables all virtual interrupts
// RQ6: trap makes return to level1 illegal
// RQ7: trap forces three debug trap bits on
// RQ8: monitor call trap catches nonsecure level1 calls
// RQ9: set/way override bit always reads one
// RQ10: second config resets zero, bit 6 unimplemented
// RQ11: second config reachable only from levels two, three
// RQ12: icache off, mmu off: fetches non-cacheable
// RQ13: icache on, mmu off: fetches write-through
// RQ14: dcache off: data and walks non-cacheable
// RQ15: system control bit 0 enables mmu
// RQ16: syndrome holds class, length, specific syndrome
// RQ17: low classes carry condition valid and field
// RQ18: trapped instruction sets valid and its condition
// RQ19: system error: uncontainable, abort type zero, code 0x11
// RQ20: synchronous external aborts keep abort type zero
// RQ21: 64-bit table base with common-not-private bit
// RQ22: auxiliary feature register reads all zero
// RQ23: reserved configuration bits read zero, ignore writes
module hcsr_regs (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  input wire logic [1:0] access_level_in,
  input wire logic nonsecure_indicator_in,
  input wire logic [31:0] level1_system_control_in,
  input wire logic [31:0] hyp_debug_config_in,
  input wire logic smc_attempt_in,
  input wire logic smc_condition_field_pass_in,
  input wire hcsr_pkg::hcsr_event_type event_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output hcsr_pkg::hcsr_effective_type effective_out,
  output hcsr_pkg::hcsr_el2_mem_type el2_mem_out,
  output logic smc_trap_out
);
  import hcsr_pkg::*;

  logic [31:0] hyp_config;
  logic [31:0] hyp_config_ext;
  logic [31:0] hyp_system_control;
  logic [31:0] hyp_exception_syndrome;
  logic [63:0] hyp_table_base;
  logic [31:0] event_count;
  logic trap_active;
  logic setup;
  logic wr_ok;
  logic rd_ok;
  logic level_ok;
  logic addr_hit;
  logic [31:0] rd_value;
  logic [31:0] next_syndrome;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // apb decode: one wait state, pready answers the second access-phase cycle
  assign setup = psel_in && penable_in && !pready_out;
  assign level_ok = (access_level_in == 2'(hcsr_el2_type)) ||
                    (access_level_in == 2'(hcsr_el3_type));

  always_comb begin
    addr_hit = 1'b1;
    rd_value = 32'h0;
    unique case (paddr_in)
      hcsr_off_config: rd_value = hyp_config | hcsr_config_res1; // RQ9
      hcsr_off_config_ext: rd_value = hyp_config_ext; // RQ10
      hcsr_off_sysctl: rd_value = hyp_system_control;
      hcsr_off_syndrome: rd_value = hyp_exception_syndrome;
      hcsr_off_table_lo: rd_value = hyp_table_base[31:0];
      hcsr_off_table_hi: rd_value = hyp_table_base[63:32];
      hcsr_off_aux_ident: rd_value = hcsr_aux_ident_value; // RQ22
      hcsr_off_status: rd_value = event_count;
      hcsr_off_core_ctrl: rd_value = {21'h0, effective_out};
      default: addr_hit = 1'b0;
    endcase
  end

  // access below level two refused only for the second configuration register
  assign rd_ok = addr_hit && !(paddr_in == hcsr_off_config_ext && !level_ok); // RQ11
  // a write lands only at the edge that completes the transfer
  assign wr_ok = psel_in && penable_in && pready_out && pwrite_in && rd_ok;

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0;
    end else begin
      pready_out <= setup;
      pslverr_out <= setup && !rd_ok;
      prdata_out <= (setup && !pwrite_in && rd_ok) ? rd_value : 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // configuration registers; writes to the two config registers held to the reserved masks, system control and table base take writes unmasked
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      hyp_config <= hcsr_config_reset; // RQ1
    end else if (wr_ok && paddr_in == hcsr_off_config) begin
      hyp_config <= (merge_bytes(hyp_config, pwdata_in, pstrb_in) & hcsr_config_wmask)
                    | hcsr_config_res1; // RQ23
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      hyp_config_ext <= hcsr_config_ext_reset; // RQ10
    end else if (wr_ok && paddr_in == hcsr_off_config_ext) begin
      // mismatched cacheability bit held zero by the all-zero mask
      hyp_config_ext <= merge_bytes(hyp_config_ext, pwdata_in, pstrb_in)
                        & hcsr_config_ext_wmask; // RQ10
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      hyp_system_control <= hcsr_sysctl_reset;
    end else if (wr_ok && paddr_in == hcsr_off_sysctl) begin
      hyp_system_control <= merge_bytes(hyp_system_control, pwdata_in, pstrb_in);
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      hyp_table_base <= hcsr_table_reset; // RQ21
    end else if (wr_ok && paddr_in == hcsr_off_table_lo) begin
      hyp_table_base[31:0] <= merge_bytes(hyp_table_base[31:0], pwdata_in, pstrb_in);
    end else if (wr_ok && paddr_in == hcsr_off_table_hi) begin
      hyp_table_base[63:32] <= merge_bytes(hyp_table_base[63:32], pwdata_in, pstrb_in);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // syndrome capture; a core event wins over a software write in the same cycle
  always_comb begin
    next_syndrome = {event_in.exception_class, event_in.instruction_length,
                     event_in.specific_syndrome}; // RQ16
    unique case (event_in.kind)
      hcsr_ev_trap: begin
        if (event_in.exception_class != 6'h0 && event_in.exception_class[5:4] == 2'b00) begin
          next_syndrome[24] = 1'b1; // RQ17 RQ18
          next_syndrome[23:20] = event_in.condition_field; // RQ18
        end
      end
      hcsr_ev_sei: begin
        next_syndrome[11:10] = hcsr_aet_uncontainable; // RQ19
        next_syndrome[9] = 1'b0; // RQ19
        next_syndrome[5:0] = hcsr_fault_status_code_sei; // RQ19
      end
      hcsr_ev_sync_data_abort, hcsr_ev_sync_prefetch_abort: begin
        next_syndrome[9] = 1'b0; // RQ20
      end
      default: begin
        if (event_in.exception_class != 6'h0 && event_in.exception_class[5:4] == 2'b00
            && !event_in.specific_syndrome[24]) begin
          next_syndrome[23:20] = 4'h0; // RQ18
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      hyp_exception_syndrome <= hcsr_syndrome_reset;
    end else if (event_in.valid) begin
      hyp_exception_syndrome <= next_syndrome; // RQ16
    end else if (wr_ok && paddr_in == hcsr_off_syndrome) begin
      hyp_exception_syndrome <= merge_bytes(hyp_exception_syndrome, pwdata_in, pstrb_in);
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      event_count <= 32'h0;
    end else if (event_in.valid) begin
      event_count <= event_count + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // effective controls; stored bits stay untouched so reads show them
  assign trap_active = hyp_config[hcsr_bit_get] && nonsecure_indicator_in; // RQ2

  logic eff_route;
  logic eff_level1_mmu;
  logic eff_fast_irq_route;
  logic eff_irq_route;
  logic eff_async_abort_route;
  logic eff_virq_enable;
  logic eff_eret_illegal;
  logic eff_dbg_rom_trap;
  logic eff_dbg_os_trap;
  logic eff_dbg_access_trap;
  logic eff_smc_trap_bit;

  // one flop per control, packed msb first as the struct lists them
  assign effective_out = {eff_route, eff_level1_mmu, eff_fast_irq_route, eff_irq_route,
                          eff_async_abort_route, eff_virq_enable, eff_eret_illegal,
                          eff_dbg_rom_trap, eff_dbg_os_trap, eff_dbg_access_trap,
                          eff_smc_trap_bit};

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      eff_route <= 1'b0;
    end else begin
      eff_route <= trap_active; // RQ2
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      eff_level1_mmu <= 1'b0;
    end else begin
      eff_level1_mmu <= level1_system_control_in[hcsr_bit_l1_mmu] && !trap_active; // RQ3
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      eff_fast_irq_route <= 1'b0;
    end else begin
      eff_fast_irq_route <= trap_active; // RQ4
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      eff_irq_route <= 1'b0;
    end else begin
      eff_irq_route <= trap_active; // RQ4
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      eff_async_abort_route <= 1'b0;
    end else begin
      eff_async_abort_route <= trap_active; // RQ4
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      eff_virq_enable <= 1'b0;
    end else begin
      eff_virq_enable <= !trap_active; // RQ5
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      eff_eret_illegal <= 1'b0;
    end else begin
      eff_eret_illegal <= trap_active; // RQ6
    end
  end

  // debug forcing keys on the stored bit alone, without the nonsecure term
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      eff_dbg_rom_trap <= 1'b0;
    end else begin
      eff_dbg_rom_trap <= hyp_debug_config_in[hcsr_bit_dbg_rom]
                          || hyp_config[hcsr_bit_get]; // RQ7
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      eff_dbg_os_trap <= 1'b0;
    end else begin
      eff_dbg_os_trap <= hyp_debug_config_in[hcsr_bit_dbg_os]
                         || hyp_config[hcsr_bit_get]; // RQ7
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      eff_dbg_access_trap <= 1'b0;
    end else begin
      eff_dbg_access_trap <= hyp_debug_config_in[hcsr_bit_dbg_access]
                             || hyp_config[hcsr_bit_get]; // RQ7
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      eff_smc_trap_bit <= 1'b0;
    end else begin
      eff_smc_trap_bit <= hyp_config[hcsr_bit_mct]; // RQ8
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      smc_trap_out <= 1'b0;
    end else begin
      smc_trap_out <= hyp_config[hcsr_bit_mct] && smc_attempt_in && smc_condition_field_pass_in
                      && nonsecure_indicator_in
                      && access_level_in == 2'(hcsr_el1_type); // RQ8
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // level two memory attributes from system control and the table base
  logic mem_mmu_en;
  logic mem_ifetch_cacheable;
  logic mem_ifetch_write_through;
  logic mem_data_cacheable;
  logic mem_walk_cacheable;
  logic mem_common_not_private;

  assign el2_mem_out = {mem_mmu_en, mem_ifetch_cacheable, mem_ifetch_write_through,
                        mem_data_cacheable, mem_walk_cacheable, mem_common_not_private};

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      mem_mmu_en <= 1'b0;
    end else begin
      mem_mmu_en <= hyp_system_control[hcsr_bit_mmu]; // RQ15
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      mem_ifetch_cacheable <= 1'b0;
    end else begin
      mem_ifetch_cacheable <= hyp_system_control[hcsr_bit_icache]; // RQ12
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      mem_ifetch_write_through <= 1'b0;
    end else begin
      mem_ifetch_write_through <= hyp_system_control[hcsr_bit_icache]
                                  && !hyp_system_control[hcsr_bit_mmu]; // RQ13
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      mem_data_cacheable <= 1'b0;
    end else begin
      mem_data_cacheable <= hyp_system_control[hcsr_bit_dcache]; // RQ14
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      mem_walk_cacheable <= 1'b0;
    end else begin
      mem_walk_cacheable <= hyp_system_control[hcsr_bit_dcache]; // RQ14
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      mem_common_not_private <= 1'b0;
    end else begin
      mem_common_not_private <= hyp_table_base[hcsr_bit_cnp]; // RQ21
    end
  end
endmodule

// file: logic/hcsr_pkg.sv
// constants, types and register map of the hypervisor control and syndrome bank
// assumes a 32-bit apb slave port and a single 100 mhz clock domain
package hcsr_pkg;
  localparam logic [7:0] hcsr_off_config = 8'h00;
  localparam logic [7:0] hcsr_off_config_ext = 8'h04;
  localparam logic [7:0] hcsr_off_sysctl = 8'h08;
  localparam logic [7:0] hcsr_off_syndrome = 8'h0c;
  localparam logic [7:0] hcsr_off_table_lo = 8'h10;
  localparam logic [7:0] hcsr_off_table_hi = 8'h14;
  localparam logic [7:0] hcsr_off_aux_ident = 8'h18;
  localparam logic [7:0] hcsr_off_status = 8'h1c;
  localparam logic [7:0] hcsr_off_core_ctrl = 8'h20;

  localparam logic [31:0] hcsr_config_reset = 32'h0000_0002;
  localparam logic [31:0] hcsr_config_ext_reset = 32'h0000_0000;
  localparam logic [31:0] hcsr_sysctl_reset = 32'h0000_0000;
  localparam logic [31:0] hcsr_syndrome_reset = 32'h0000_0000;
  localparam logic [63:0] hcsr_table_reset = 64'h0;
  localparam logic [31:0] hcsr_aux_ident_value = 32'h0000_0000;

  // writable bits of the configuration register; others read zero except the set/way override bit, which reads one
  localparam logic [31:0] hcsr_config_wmask = 32'h0808_0000;
  localparam logic [31:0] hcsr_config_res1 = 32'h0000_0002;
  localparam logic [31:0] hcsr_config_ext_wmask = 32'h0000_0000;

  localparam int hcsr_bit_get = 27;
  localparam int hcsr_bit_mct = 19;
  localparam int hcsr_bit_setway_inval_override = 1;
  localparam int hcsr_bit_mcnc = 6;
  localparam int hcsr_bit_icache = 12;
  localparam int hcsr_bit_dcache = 2;
  localparam int hcsr_bit_mmu = 0;
  localparam int hcsr_bit_cnp = 0;
  localparam int hcsr_bit_l1_mmu = 0;
  localparam int hcsr_bit_dbg_rom = 11;
  localparam int hcsr_bit_dbg_os = 10;
  localparam int hcsr_bit_dbg_access = 9;

  localparam logic [1:0] hcsr_aet_uncontainable = 2'h0;
  localparam logic [5:0] hcsr_fault_status_code_sei = 6'h11;
  localparam logic [4:0] hcsr_ctrl_sw = 5'h0;

  typedef enum logic [1:0] {
    hcsr_el0_type,
    hcsr_el1_type,
    hcsr_el2_type,
    hcsr_el3_type
  } hcsr_level_type;

  typedef enum logic [2:0] {
    hcsr_ev_trap,
    hcsr_ev_sei,
    hcsr_ev_sync_data_abort,
    hcsr_ev_sync_prefetch_abort,
    hcsr_ev_other
  } hcsr_event_kind_type;

  typedef struct packed {
    logic valid;
    hcsr_event_kind_type kind;
    logic [5:0] exception_class;
    logic instruction_length;
    logic [3:0] condition_field;
    logic [24:0] specific_syndrome;
  } hcsr_event_type;

  typedef struct packed {
    logic route_el1_to_el2;
    logic level1_mmu_effective;
    logic fast_irq_route;
    logic irq_route;
    logic async_abort_route;
    logic virq_enable;
    logic eret_el1_illegal;
    logic debug_rom_access_trap;
    logic debug_os_access_trap;
    logic debug_access_trap;
    logic smc_trap;
  } hcsr_effective_type;

  typedef struct packed {
    logic mmu_en;
    logic ifetch_cacheable;
    logic ifetch_write_through;
    logic data_cacheable;
    logic walk_cacheable;
    logic common_not_private;
  } hcsr_el2_mem_type;
endpackage

// file: test/hcsr_regs_asserts.sv
// assertions on the hypervisor control and syndrome bank ports
// bound to hcsr_regs from the bench top; one clock, sync reset
`timescale 1ns/1ps
module hcsr_regs_asserts (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic [7:0] paddr_in,
  input wire logic [1:0] access_level_in,
  input wire logic nonsecure_indicator_in,
  input wire logic [31:0] level1_system_control_in,
  input wire logic smc_attempt_in,
  input wire logic smc_condition_field_pass_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire hcsr_pkg::hcsr_effective_type effective_out,
  input wire hcsr_pkg::hcsr_el2_mem_type el2_mem_out,
  input wire logic smc_trap_out
);
  import hcsr_pkg::*;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  ////////////////////////////////////////
  wire logic rt = effective_out.route_el1_to_el2;
  property p_route; rt |-> $past(nonsecure_indicator_in); endproperty
  a_route: assert property (p_route) else $error("route without nonsecure");
  property p_l1mmu;
    effective_out.level1_mmu_effective |-> !rt && $past(level1_system_control_in[0]);
  endproperty
  a_l1mmu: assert property (p_l1mmu) else $error("level1 mmu not masked");
  property p_force;
    rt |-> effective_out.fast_irq_route && effective_out.irq_route
      && effective_out.async_abort_route;
  endproperty
  a_force: assert property (p_force) else $error("routing bits not forced");
  property p_virq; rt |-> !effective_out.virq_enable; endproperty
  a_virq: assert property (p_virq) else $error("virtual irq left on");
  property p_eret; rt |-> effective_out.eret_el1_illegal; endproperty
  a_eret: assert property (p_eret) else $error("level1 return not illegal");
  property p_dbg;
    rt |-> effective_out.debug_rom_access_trap && effective_out.debug_os_access_trap
      && effective_out.debug_access_trap;
  endproperty
  a_dbg: assert property (p_dbg) else $error("debug traps not forced");
  // only the cause side is checked; the stored enable is not a port
  property p_smc;
    smc_trap_out |-> $past(smc_attempt_in && smc_condition_field_pass_in
      && nonsecure_indicator_in && access_level_in == 2'h1);
  endproperty
  a_smc: assert property (p_smc) else $error("monitor call trap without cause");
  property p_ext;
    psel_in && penable_in && !pready_out && paddr_in == hcsr_off_config_ext
      && access_level_in < 2'h2 |=> pready_out && pslverr_out;
  endproperty
  a_ext: assert property (p_ext) else $error("low level reached second config");
  property p_err; pslverr_out |-> pready_out && prdata_out == 32'h0; endproperty
  a_err: assert property (p_err) else $error("error reply with data");
  property p_wt;
    !el2_mem_out.ifetch_cacheable |-> !el2_mem_out.ifetch_write_through;
  endproperty
  a_wt: assert property (p_wt) else $error("write-through with icache off");
  property p_walk; el2_mem_out.data_cacheable == el2_mem_out.walk_cacheable; endproperty
  a_walk: assert property (p_walk) else $error("walk and data differ");
  c_read: cover property (pready_out && !pslverr_out);
  c_err: cover property (pslverr_out);
  c_route: cover property (rt);
  c_smc: cover property (smc_trap_out);
endmodule

// file: test/hcsr_regs_tb_top.sv
// self-checking bench for the hypervisor control and syndrome bank
// drives apb and core status ports directly; no partner model
`timescale 1ns/1ps
module hcsr_regs_tb_top;
  import hcsr_pkg::*;
  logic clk_sys_in, sys_rst_in, psel_in, penable_in, pwrite_in;
  logic [7:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, level1_system_control_in, hyp_debug_config_in;
  logic [3:0] pstrb_in;
  logic [1:0] access_level_in;
  logic nonsecure_indicator_in, smc_attempt_in, smc_condition_field_pass_in;
  logic pready_out, pslverr_out, smc_trap_out;
  hcsr_event_type event_in;
  hcsr_effective_type effective_out;
  hcsr_el2_mem_type el2_mem_out;
  int err_count = 0;
  int n_tests = 0;
  hcsr_regs dut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .access_level_in(access_level_in),
    .nonsecure_indicator_in(nonsecure_indicator_in),
    .level1_system_control_in(level1_system_control_in),
    .hyp_debug_config_in(hyp_debug_config_in), .smc_attempt_in(smc_attempt_in),
    .smc_condition_field_pass_in(smc_condition_field_pass_in), .event_in(event_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .effective_out(effective_out),
    .el2_mem_out(el2_mem_out), .smc_trap_out(smc_trap_out));
  ////////////////////////////////////////
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  task automatic wrap_up();
    if (err_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // waits for pready without a bound; a hang is ended by the watchdog
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, e,
    input logic er);
    @(posedge clk_sys_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clk_sys_in);
    end while (pready_out !== 1'b1);
    if (!w) chk(prdata_out, e);
    chk({31'h0, pslverr_out}, {31'h0, er});
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic ev(input hcsr_event_kind_type k, input logic [5:0] c,
    input logic [3:0] cd, input logic [24:0] s, input logic [31:0] e);
    @(posedge clk_sys_in);
    event_in <= '{1'b1, k, c, 1'b1, cd, s};
    @(posedge clk_sys_in);
    event_in <= '0;
    acc(1'b0, hcsr_off_syndrome, 32'h0, e, 1'b0);
  endtask
  initial begin
    repeat (5000) @(posedge clk_sys_in);
    err_count++;
    wrap_up();
  end
  ////////////////////////////////////////
  initial begin
    {sys_rst_in, psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
    sys_rst_in = 1'b1;
    pstrb_in = 4'hf;
    access_level_in = 2'h2;
    nonsecure_indicator_in = 1'b1;
    level1_system_control_in = 32'h1;
    hyp_debug_config_in = 32'h0;
    {smc_attempt_in, smc_condition_field_pass_in} = 2'h0;
    event_in = '0;
    repeat (20) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    acc(1'b0, hcsr_off_config, 32'h0, 32'h2, 1'b0);
    acc(1'b0, hcsr_off_config_ext, 32'h0, 32'h0, 1'b0);
    chk({21'h0, effective_out}, 32'h220);
    acc(1'b1, hcsr_off_config, 32'hffffffff, 32'h0, 1'b0);
    acc(1'b0, hcsr_off_config, 32'h0, 32'h08080002, 1'b0);
    chk({21'h0, effective_out}, 32'h5df);
    acc(1'b0, hcsr_off_core_ctrl, 32'h0, 32'h5df, 1'b0);
    nonsecure_indicator_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    chk({21'h0, effective_out}, 32'h22f);
    acc(1'b1, hcsr_off_config_ext, 32'hffffffff, 32'h0, 1'b0);
    acc(1'b0, hcsr_off_config_ext, 32'h0, 32'h0, 1'b0);
    access_level_in <= 2'h1;
    acc(1'b0, hcsr_off_config_ext, 32'h0, 32'h0, 1'b1);
    acc(1'b1, hcsr_off_config_ext, 32'h0, 32'h0, 1'b1);
    access_level_in <= 2'h3;
    acc(1'b0, 8'h40, 32'h0, 32'h0, 1'b1);
    acc(1'b1, hcsr_off_aux_ident, 32'hffffffff, 32'h0, 1'b0);
    acc(1'b0, hcsr_off_aux_ident, 32'h0, 32'h0, 1'b0);
    acc(1'b1, hcsr_off_table_lo, 32'h12345679, 32'h0, 1'b0);
    acc(1'b1, hcsr_off_table_hi, 32'hdeadbeef, 32'h0, 1'b0);
    acc(1'b0, hcsr_off_table_lo, 32'h0, 32'h12345679, 1'b0);
    acc(1'b0, hcsr_off_table_hi, 32'h0, 32'hdeadbeef, 1'b0);
    acc(1'b1, hcsr_off_sysctl, 32'h1004, 32'h0, 1'b0);
    repeat (2) @(posedge clk_sys_in);
    chk({26'h0, el2_mem_out}, 32'h1f);
    acc(1'b1, hcsr_off_sysctl, 32'h1, 32'h0, 1'b0);
    repeat (2) @(posedge clk_sys_in);
    chk({26'h0, el2_mem_out}, 32'h21);
    nonsecure_indicator_in <= 1'b1;
    access_level_in <= 2'h1;
    {smc_attempt_in, smc_condition_field_pass_in} <= 2'h3;
    repeat (2) @(posedge clk_sys_in);
    chk({31'h0, smc_trap_out}, 32'h1);
    smc_condition_field_pass_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    chk({31'h0, smc_trap_out}, 32'h0);
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    acc(1'b0, hcsr_off_config, 32'h0, 32'h2, 1'b0);
    acc(1'b0, hcsr_off_table_lo, 32'h0, 32'h0, 1'b0);
    access_level_in <= 2'h2;
    ev(hcsr_ev_trap, 6'h01, 4'ha, 25'h0000123, 32'h07a00123);
    ev(hcsr_ev_sei, 6'h2f, 4'h0, 25'h1ffffff, 32'hbffff1d1);
    ev(hcsr_ev_sync_data_abort, 6'h24, 4'h0, 25'h1ffffff, 32'h93fffdff);
    ev(hcsr_ev_sync_prefetch_abort, 6'h20, 4'h0, 25'h1ffffff, 32'h83fffdff);
    acc(1'b0, hcsr_off_status, 32'h0, 32'h4, 1'b0);
    wrap_up();
  end
endmodule
bind hcsr_regs hcsr_regs_asserts u_chk (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
  .psel_in(psel_in), .penable_in(penable_in), .paddr_in(paddr_in),
  .access_level_in(access_level_in), .nonsecure_indicator_in(nonsecure_indicator_in),
  .level1_system_control_in(level1_system_control_in), .smc_attempt_in(smc_attempt_in),
  .smc_condition_field_pass_in(smc_condition_field_pass_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .effective_out(effective_out), .el2_mem_out(el2_mem_out),
  .smc_trap_out(smc_trap_out));
